/* File: hdl/twc_top.sv */
// Register slice of the two-wire controller: enables, mask view, status and holding bytes
//
// How it works
// - Disable write: each one bit clears its enable, zero bits change nothing.
// - Mask view read returns one for each enabled source, zero otherwise.
// - Bit 0 transfer done, bit 1 rx ready, bit 2 tx free; bit 3 unused.
// - Bit 4 addressed as target, 5 general call, 6 overrun; bit 7 unused.
// - Bit 8 no ack, 9 arbitration lost, 10 stretch, 11 access over; rest unused.
// - Mask view shares that layout and ignores writes.
// - Rx holding register shows the last received byte in its low byte; read-only.
// - Tx holding register takes the next byte to send; reads return zero.
// - Enable write: each one bit sets its enable, zero bits change nothing.
// - Rx ready sets when a byte lands and clears on a holding register read.
// - Tx free clears on a holding write and sets when the shifter takes the byte.
//
// Our own choices: the strobed register port and the placing of the registers.
`default_nettype none

module twc_top (
	// Clock, reset and enable
	input  wire logic                        ref_clk,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en,
	// Register port
	input  wire twc_pkg::twc_bus_s           bus,
	output logic      [twc_pkg::DATA_W-1:0]  rd_data,
	// Shift engine side
	input  wire twc_pkg::twc_eng_s           eng,
	output logic      [twc_pkg::BYTE_W-1:0]  tx_byte_value,
	output logic                             tx_slot_free,
	output logic                             rx_byte_ready,
	// Interrupt
	output logic                             irq
);

	// ************************************************************
	// Helpers
	// ************************************************************

	// Widen an event map to a bus word, unused bits zero
	function automatic logic [twc_pkg::DATA_W-1:0] widen_evt(input logic [twc_pkg::EVT_W-1:0] v);
		logic [twc_pkg::DATA_W-1:0] w;
		w                         = twc_pkg::WORD_ZERO;
		w[twc_pkg::EVT_W-1:0]     = v & twc_pkg::EVT_VALID;
		return w;
	endfunction : widen_evt

	// Address match qualified by a strobe
	function automatic logic hit(input logic strobe, input logic [twc_pkg::ADDR_W-1:0] a,
		input logic [twc_pkg::ADDR_W-1:0] off);
		return strobe && (a == off);
	endfunction : hit

	// ************************************************************
	// Decode
	// ************************************************************

	logic                         wr_enable;
	logic                         wr_disable;
	logic                         wr_tx;
	logic                         rd_rx;
	logic                         rd_status;
	logic [twc_pkg::EVT_W-1:0]    en_set;
	logic [twc_pkg::EVT_W-1:0]    en_clr;
	logic [twc_pkg::EVT_W-1:0]    evt;
	logic [twc_pkg::EVT_W-1:0]    level;
	logic [twc_pkg::EVT_W-1:0]    enabled;
	logic [twc_pkg::EVT_W-1:0]    status;
	logic [twc_pkg::BYTE_W-1:0]   rx_value;
	logic                         rx_full;
	logic                         tx_full;
	logic                         overrun;

	// Strobes per register; writes to the view and status land nowhere
	assign wr_enable  = hit(bus.wr, bus.addr, twc_pkg::OFF_IRQ_ENABLE);
	assign wr_disable = hit(bus.wr, bus.addr, twc_pkg::OFF_IRQ_DISABLE);
	assign wr_tx      = hit(bus.wr, bus.addr, twc_pkg::OFF_TX_HOLD);
	assign rd_rx      = hit(bus.rd, bus.addr, twc_pkg::OFF_RX_HOLD);
	assign rd_status  = hit(bus.rd, bus.addr, twc_pkg::OFF_STATUS);

	// Enable and disable words use the same bit map
	assign en_set = wr_enable ? bus.wdata[twc_pkg::EVT_W-1:0] : '0;
	assign en_clr = wr_disable ? bus.wdata[twc_pkg::EVT_W-1:0] : '0;

	// A byte landing on an unread one is an overrun
	assign overrun = eng.rx_load && rx_full && !rd_rx;

	// Event sources folded onto the shared bit map
	always_comb begin
		evt                         = eng.evt & twc_pkg::STICKY_MASK;
		evt[twc_pkg::BIT_RX_OVERRUN] = evt[twc_pkg::BIT_RX_OVERRUN] | overrun;
		level                       = '0;
		level[twc_pkg::BIT_RX_BYTE_READY] = rx_full;
		level[twc_pkg::BIT_TX_SLOT_FREE]  = !tx_full;
	end

	// ************************************************************
	// Submodules
	// ************************************************************

	twc_irq_ctrl #(
		.N         (twc_pkg::EVT_W)
	) u_irq (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.en_set    (en_set),
		.en_clr    (en_clr),
		.status_rd (rd_status),
		.evt       (evt),
		.level     (level),
		.enabled   (enabled),
		.status    (status),
		.irq       (irq)
	);

	// Receive holding byte: filled by the engine, drained by software
	twc_hold_reg #(
		.WIDTH     (twc_pkg::BYTE_W)
	) u_rx (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.load      (eng.rx_load),
		.load_data (eng.rx_byte),
		.take      (rd_rx),
		.data      (rx_value),
		.full      (rx_full)
	);

	// Transmit holding byte: filled by software, drained by the shifter
	twc_hold_reg #(
		.WIDTH     (twc_pkg::BYTE_W)
	) u_tx (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.load      (wr_tx),
		.load_data (bus.wdata[twc_pkg::BYTE_W-1:0]),
		.take      (eng.tx_take),
		.data      (tx_byte_value),
		.full      (tx_full)
	);

	// ************************************************************
	// Read data and flag outputs
	// ************************************************************

	typedef struct packed {
		logic [twc_pkg::DATA_W-1:0] rd_data;
		logic                       rx_ready;
		logic                       tx_free;
	} twc_top_s;

	twc_top_s st;
	twc_top_s next_st;

	// Read data stand only in the cycle after the strobe; unmapped reads give zero
	always_comb begin
		next_st          = st;
		next_st.rd_data  = twc_pkg::WORD_ZERO;
		next_st.rx_ready = level[twc_pkg::BIT_RX_BYTE_READY];
		next_st.tx_free  = level[twc_pkg::BIT_TX_SLOT_FREE];
		if (eng.rx_load) begin
			next_st.rx_ready = 1'h1;
		end else if (rd_rx) begin
			next_st.rx_ready = 1'h0;
		end
		if (wr_tx) begin
			next_st.tx_free = 1'h0;
		end else if (eng.tx_take) begin
			next_st.tx_free = 1'h1;
		end
		if (bus.rd) begin
			case (bus.addr)
				twc_pkg::OFF_IRQ_VIEW: begin
					next_st.rd_data = widen_evt(enabled);
				end
				twc_pkg::OFF_STATUS: begin
					next_st.rd_data = widen_evt(status);
				end
				twc_pkg::OFF_RX_HOLD: begin
					next_st.rd_data[twc_pkg::BYTE_W-1:0] = rx_value;
				end
				default: begin
					next_st.rd_data = twc_pkg::WORD_ZERO;
				end
			endcase
		end
	end

	// Output registers mirror the holding flags so every output is a flop
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '{rd_data: twc_pkg::WORD_ZERO, rx_ready: 1'h0, tx_free: 1'h1};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign rd_data       = st.rd_data;
	assign rx_byte_ready = st.rx_ready;
	assign tx_slot_free  = st.tx_free;

	// ************************************************************
	// Assertions
	// ************************************************************

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// Enable, disable and view registers
	a_disable_clears_en: assert property (clk_en && wr_disable |=>
		(enabled & $past(en_clr)) == '0)
		else $error("disable write left an enable set");

	a_enable_sets_en: assert property (clk_en && wr_enable |=>
		((enabled & $past(en_set) & twc_pkg::EVT_VALID) == ($past(en_set) & twc_pkg::EVT_VALID)))
		else $error("enable write did not set enables");

	a_zero_bits_keep: assert property (clk_en && (wr_enable || wr_disable) |=>
		((enabled ^ $past(enabled)) & ~($past(en_set) | $past(en_clr))) == '0)
		else $error("zero bits changed an enable");

	a_enable_unused: assert property (clk_en && wr_enable |=>
		(enabled & ~twc_pkg::EVT_VALID) == '0)
		else $error("unused enable bit set");

	a_view_read_value: assert property (clk_en && hit(bus.rd, bus.addr, twc_pkg::OFF_IRQ_VIEW) |=>
		rd_data == widen_evt($past(enabled)))
		else $error("mask view read wrong");

	// Byte reads carry data in bits 7 to 0, so they are judged separately
	a_unused_bits_zero: assert property (clk_en && bus.rd && bus.addr != twc_pkg::OFF_RX_HOLD |=>
		rd_data[twc_pkg::DATA_W-1:twc_pkg::EVT_W] == '0 &&
		(rd_data[twc_pkg::EVT_W-1:0] & ~twc_pkg::EVT_VALID) == '0)
		else $error("unused read bits not zero");

	a_view_read_only: assert property (clk_en && hit(bus.wr, bus.addr, twc_pkg::OFF_IRQ_VIEW) |=>
		enabled == $past(enabled))
		else $error("write to mask view changed enables");

	// Holding bytes and their flags
	a_rx_byte_lands: assert property (clk_en && eng.rx_load |=> rx_value == $past(eng.rx_byte))
		else $error("received byte not held");

	a_rx_read_value: assert property (clk_en && rd_rx |=>
		rd_data[twc_pkg::BYTE_W-1:0] == $past(rx_value) && rd_data[twc_pkg::DATA_W-1:twc_pkg::BYTE_W] == '0)
		else $error("rx holding read wrong");

	a_tx_read_zero: assert property (clk_en && hit(bus.rd, bus.addr, twc_pkg::OFF_TX_HOLD) |=>
		rd_data == twc_pkg::WORD_ZERO)
		else $error("tx holding read not zero");

	a_rx_ready_cycle: assert property (clk_en && rd_rx && !eng.rx_load |=> !rx_byte_ready ##0 !rx_full)
		else $error("rx ready not cleared by read");

	a_rx_ready_set: assert property (clk_en && eng.rx_load |=>
		rx_byte_ready && status[twc_pkg::BIT_RX_BYTE_READY])
		else $error("rx ready not set by load");

	a_tx_write: assert property (clk_en && wr_tx && !eng.tx_take |=>
		!tx_slot_free && tx_byte_value == $past(bus.wdata[twc_pkg::BYTE_W-1:0]))
		else $error("tx write not held");

	a_tx_take: assert property (clk_en && eng.tx_take && !wr_tx |=> tx_slot_free)
		else $error("tx free not set on take");

	// The output flops are built apart from the holding flags, so they must agree
	a_level_mirror: assert property (rx_byte_ready == status[twc_pkg::BIT_RX_BYTE_READY] &&
		tx_slot_free == status[twc_pkg::BIT_TX_SLOT_FREE])
		else $error("ready flags disagree with status");

	// Status bits and the interrupt line
	a_event_sticky: assert property (clk_en && eng.evt != '0 |=>
		(status & $past(eng.evt) & twc_pkg::STICKY_MASK) == ($past(eng.evt) & twc_pkg::STICKY_MASK))
		else $error("event not held in status");

	a_overrun_flag: assert property (clk_en && overrun |=> status[twc_pkg::BIT_RX_OVERRUN])
		else $error("overrun not flagged");

	a_status_read_clr: assert property (clk_en && rd_status && eng.evt == '0 && !overrun |=>
		(status & twc_pkg::STICKY_MASK) == '0)
		else $error("status read left a sticky bit");

	a_irq_follows: assert property (clk_en && ((status & enabled) != '0) |-> ##[0:1] irq)
		else $error("interrupt missing");

	a_irq_quiet: assert property (clk_en [*2] ##0 ((status & enabled) == '0) [*2] |-> !irq)
		else $error("interrupt without cause");

	a_irq_masked_off: assert property (clk_en && enabled == '0 && !wr_enable |=> !irq)
		else $error("interrupt with all sources disabled");

	// A low clock enable must leave every register as it was
	a_frozen_hold: assert property (!clk_en |=>
		enabled == $past(enabled) && status == $past(status) &&
		rd_data == $past(rd_data) && tx_byte_value == $past(tx_byte_value))
		else $error("state moved while frozen");

	// Main scenarios: overrun, interrupt rise, tx round trip, drain beside load, freeze
	c_rx_overrun: cover property (clk_en && overrun);
	c_irq_raise: cover property (!irq ##1 irq);
	c_tx_round: cover property (clk_en && wr_tx ##[1:20] clk_en && eng.tx_take);
	c_rx_drain_load: cover property (clk_en && rd_rx && eng.rx_load);
	c_freeze_resume: cover property (!clk_en ##1 clk_en);

endmodule : twc_top

`default_nettype wire

/* File: hdl/twc_pkg.sv */
// Shared constants and carrier types for the two-wire controller register slice
`default_nettype none

package twc_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned EVT_W  = 12;
	localparam int unsigned BYTE_W = 8;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_IRQ_DISABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_VIEW    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_RX_HOLD     = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TX_HOLD     = 8'h14;

	// ************************************************************
	// Event bit positions, common to enable, disable, view and status
	// ************************************************************
	localparam int unsigned BIT_TRANSFER_DONE       = 0;
	localparam int unsigned BIT_RX_BYTE_READY       = 1;
	localparam int unsigned BIT_TX_SLOT_FREE        = 2;
	localparam int unsigned BIT_ADDRESSED_AS_TARGET = 4;
	localparam int unsigned BIT_GENERAL_CALL_SEEN   = 5;
	localparam int unsigned BIT_RX_OVERRUN          = 6;
	localparam int unsigned BIT_NO_ACK_SEEN         = 8;
	localparam int unsigned BIT_ARBITRATION_LOST    = 9;
	localparam int unsigned BIT_CLOCK_STRETCH       = 10;
	localparam int unsigned BIT_TARGET_ACCESS_OVER  = 11;

	// Implemented bits; 3, 7 and 12 upward read as zero
	localparam logic [EVT_W-1:0] EVT_VALID   = 12'hF77;
	// Bits held as levels by the holding registers, not sticky
	localparam logic [EVT_W-1:0] LEVEL_MASK  = 12'h006;
	localparam logic [EVT_W-1:0] STICKY_MASK = 12'hF71;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [EVT_W-1:0]  EN_RESET   = 12'h000;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} twc_bus_s;

	typedef struct packed {
		logic              rx_load;
		logic [BYTE_W-1:0] rx_byte;
		logic              tx_take;
		logic [EVT_W-1:0]  evt;
	} twc_eng_s;

endpackage : twc_pkg

`default_nettype wire

/* File: hdl/twc_hold_reg.sv */
// One holding byte register with its full flag
`default_nettype none

module twc_hold_reg #(
	parameter int unsigned WIDTH = twc_pkg::BYTE_W
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	// Filling side
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_data,
	// Draining side
	input  wire logic             take,
	output logic      [WIDTH-1:0] data,
	output logic                  full
);

	typedef struct packed {
		logic [WIDTH-1:0] data;
		logic             full;
	} twc_hold_s;

	twc_hold_s st;
	twc_hold_s next_st;

	// Load wins over a take in the same cycle, so no byte is lost
	always_comb begin
		next_st = st;
		if (take) begin
			next_st.full = 1'h0;
		end
		if (load) begin
			next_st.data = load_data;
			next_st.full = 1'h1;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '{data: '0, full: 1'h0};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign data = st.data;
	assign full = st.full;

endmodule : twc_hold_reg

`default_nettype wire

/* File: hdl/twc_irq_ctrl.sv */
// Interrupt enables, sticky status and the single interrupt line
`default_nettype none

module twc_irq_ctrl #(
	parameter int unsigned N = twc_pkg::EVT_W
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	// Software controls
	input  wire logic [N-1:0] en_set,
	input  wire logic [N-1:0] en_clr,
	input  wire logic         status_rd,
	// Event sources
	input  wire logic [N-1:0] evt,
	input  wire logic [N-1:0] level,
	// State
	output logic      [N-1:0] enabled,
	output logic      [N-1:0] status,
	output logic              irq
);

	typedef struct packed {
		logic [N-1:0] en;
		logic [N-1:0] sticky;
		logic         irq;
	} twc_irq_s;

	twc_irq_s st;
	twc_irq_s next_st;

	// Enables follow set and clear strobes; an event beats a read clear
	always_comb begin
		next_st        = st;
		next_st.en     = (st.en | en_set) & ~en_clr & twc_pkg::EVT_VALID;
		next_st.sticky = status_rd ? '0 : st.sticky;
		next_st.sticky = (next_st.sticky | evt) & twc_pkg::STICKY_MASK;
		next_st.irq    = |((next_st.sticky | (level & twc_pkg::LEVEL_MASK)) & next_st.en);
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '{en: twc_pkg::EN_RESET, sticky: '0, irq: 1'h0};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign enabled = st.en;
	assign status  = st.sticky | (level & twc_pkg::LEVEL_MASK);
	assign irq     = st.irq;

endmodule : twc_irq_ctrl

`default_nettype wire

/* File: verification/twc_top_tb.sv */
// Self-checking testbench for the two-wire controller register slice
`default_nettype none

module twc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Signals and reference model state
	// ************************************************************
	logic                       ref_clk;
	logic                       sys_rst;
	logic                       clk_en;
	twc_pkg::twc_bus_s          bus;
	twc_pkg::twc_eng_s          eng;
	logic [twc_pkg::DATA_W-1:0] rd_data;
	logic [twc_pkg::BYTE_W-1:0] tx_byte_value;
	logic                       tx_slot_free;
	logic                       rx_byte_ready;
	logic                       irq;
	int                         fail_count;
	int                         cmp_count;
	int unsigned                m_en, m_st, m_rxr, m_txf, m_rxb, m_txb;
	logic [7:0]                 offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h3C};

	twc_top uut (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.clk_en        (clk_en),
		.bus           (bus),
		.rd_data       (rd_data),
		.eng           (eng),
		.tx_byte_value (tx_byte_value),
		.tx_slot_free  (tx_slot_free),
		.rx_byte_ready (rx_byte_ready),
		.irq           (irq)
	);

	// Free-running 10 MHz clock
	always #50 ref_clk = ~ref_clk;

	// ************************************************************
	// Checking and bus tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic mreset();
		m_en  = 0;
		m_st  = 0;
		m_rxr = 0;
		m_txf = 1;
		m_rxb = 0;
		m_txb = 0;
	endtask : mreset

	// One request cycle then one idle cycle; irq is judged two edges after the last cause
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d, input logic ld,
		input logic [7:0] b, input logic tk, input logic [11:0] ev, input logic ce = 1'h1);
		logic [31:0] exp;
		int unsigned lv;
		@(posedge ref_clk);
		bus    <= '{wr: w, rd: r, addr: a, wdata: d};
		eng    <= '{rx_load: ld, rx_byte: b, tx_take: tk, evt: ev};
		clk_en <= ce;
		#1;
		lv = m_st | (m_rxr << 1) | (m_txf << 2);
		chk(32'(irq), 32'(|(lv & m_en)), "irq level");
		@(posedge ref_clk);
		bus    <= '0;
		eng    <= '0;
		clk_en <= 1'h1;
		#1;
		exp = '0;
		if (ce) begin
			if (r && a == twc_pkg::OFF_IRQ_VIEW) exp = 32'(m_en);
			if (r && a == twc_pkg::OFF_STATUS) exp = 32'(lv);
			if (r && a == twc_pkg::OFF_RX_HOLD) exp = 32'(m_rxb);
			if (r && a == twc_pkg::OFF_STATUS) m_st = 0;
			// Overrun only when the unread byte is not drained in the same cycle
			if (ld) begin
				if (m_rxr == 1 && !(r && a == twc_pkg::OFF_RX_HOLD)) m_st |= 32'h40;
				m_rxb = b;
				m_rxr = 1;
			end else if (r && a == twc_pkg::OFF_RX_HOLD) m_rxr = 0;
			if (w && a == twc_pkg::OFF_TX_HOLD) begin
				m_txb = d[7:0];
				m_txf = 0;
			end else if (tk) m_txf = 1;
			m_st |= ev & 12'hF71;
			if (w && a == twc_pkg::OFF_IRQ_ENABLE) m_en |= d & 32'hF77;
			if (w && a == twc_pkg::OFF_IRQ_DISABLE) m_en &= ~d;
		end
		chk(rd_data, exp, "read data");
		chk(32'(tx_byte_value), 32'(m_txb), "tx byte");
		chk(32'(tx_slot_free), 32'(m_txf), "tx free");
		chk(32'(rx_byte_ready), 32'(m_rxr), "rx ready");
	endtask : op

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		op(1'h1, 1'h0, a, d, 1'h0, 8'h00, 1'h0, 12'h000);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		op(1'h0, 1'h1, a, 32'h0, 1'h0, 8'h00, 1'h0, 12'h000);
	endtask : rd

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		logic [7:0]  b;
		logic [31:0] d;
		ref_clk    = 1'h0;
		sys_rst    = 1'h1;
		clk_en     = 1'h1;
		bus        = '0;
		eng        = '0;
		fail_count = 0;
		cmp_count  = 0;
		mreset();
		void'($urandom(48640));
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'h0;
		foreach (offs[i]) rd(offs[i]);
		$display("test reset values done");
		// Each bit alone, unused positions included
		for (int i = 0; i < 16; i++) begin
			wr(twc_pkg::OFF_IRQ_ENABLE, 32'h1 << i);
			rd(twc_pkg::OFF_IRQ_VIEW);
			wr(twc_pkg::OFF_IRQ_DISABLE, 32'h1 << i);
			rd(twc_pkg::OFF_IRQ_VIEW);
		end
		$display("test bit positions done");
		// Random set and clear masks, writes to the view are ignored
		for (int i = 0; i < 20; i++) begin
			wr(twc_pkg::OFF_IRQ_ENABLE, $urandom);
			wr(twc_pkg::OFF_IRQ_DISABLE, $urandom);
			wr(twc_pkg::OFF_IRQ_VIEW, 32'hFFFF_FFFF);
			rd(twc_pkg::OFF_IRQ_VIEW);
		end
		wr(twc_pkg::OFF_IRQ_DISABLE, 32'hFFFF_FFFF);
		$display("test random masks done");
		// Every event raised enabled, then once all masked
		for (int i = 0; i < 12; i++) begin
			wr(twc_pkg::OFF_IRQ_ENABLE, 32'h1 << i);
			op(1'h0, 1'h0, 8'h00, 32'h0, 1'h0, 8'h00, 1'h0, 12'h1 << i);
			rd(twc_pkg::OFF_STATUS);
			wr(twc_pkg::OFF_IRQ_DISABLE, 32'h1 << i);
		end
		op(1'h0, 1'h0, 8'h00, 32'h0, 1'h0, 8'h00, 1'h0, 12'hFFF);
		op(1'h0, 1'h1, twc_pkg::OFF_STATUS, 32'h0, 1'h0, 8'h00, 1'h0, 12'h800);
		rd(twc_pkg::OFF_STATUS);
		$display("test events done");
		// Receive bytes, overrun and load beside a drain
		wr(twc_pkg::OFF_IRQ_ENABLE, 32'h42);
		for (int i = 0; i < 10; i++) begin
			b = 8'($urandom);
			op(1'h0, 1'h0, 8'h00, 32'h0, 1'h1, b, 1'h0, 12'h000);
			if (i % 3 == 0) op(1'h0, 1'h0, 8'h00, 32'h0, 1'h1, ~b, 1'h0, 12'h000);
			if (i % 3 == 1) op(1'h0, 1'h1, twc_pkg::OFF_RX_HOLD, 32'h0, 1'h1, ~b, 1'h0, 12'h000);
			rd(twc_pkg::OFF_STATUS);
			rd(twc_pkg::OFF_RX_HOLD);
		end
		wr(twc_pkg::OFF_RX_HOLD, 32'h0000_00A5);
		rd(twc_pkg::OFF_RX_HOLD);
		$display("test receive path done");
		// Transmit bytes, write beside a take, write-only read
		wr(twc_pkg::OFF_IRQ_ENABLE, 32'h4);
		for (int i = 0; i < 6; i++) begin
			d = $urandom;
			wr(twc_pkg::OFF_TX_HOLD, d);
			rd(twc_pkg::OFF_TX_HOLD);
			op(1'h1, 1'h0, twc_pkg::OFF_TX_HOLD, ~d, 1'h0, 8'h00, 1'h1, 12'h000);
			op(1'h0, 1'h0, 8'h00, 32'h0, 1'h0, 8'h00, 1'h1, 12'h000);
		end
		$display("test transmit path done");
		// Frozen cycle, then reset in mid-run
		op(1'h1, 1'h0, twc_pkg::OFF_IRQ_ENABLE, 32'hFFF, 1'h1, 8'h3C, 1'h1, 12'hFFF, 1'h0);
		rd(twc_pkg::OFF_IRQ_VIEW);
		rd(twc_pkg::OFF_STATUS);
		wr(twc_pkg::OFF_IRQ_ENABLE, 32'hFFF);
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'h0;
		mreset();
		rd(twc_pkg::OFF_IRQ_VIEW);
		rd(twc_pkg::OFF_STATUS);
		$display("test freeze and reset done");
		test_done();
	end

	// Watchdog: the scenarios need well under 1,000 cycles
	initial begin
		#200_000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		test_done();
	end

endmodule : twc_top_tb

`default_nettype wire
